// >>> hbc_map.svh
// constant map for the host bus control pins block
// Operation
// - With the bus style select high, the interrupt pin drives both levels when modem_ctrl_reg bit 5 is 1 and acts as open-source when it is 0.
// - With the bus style select high, rd_strobe_n is an active-low read strobe that the host pulses low to read.
// - With the bus style select high, wr_strobe_n is an active-low write strobe that the host drives low to write.
// - With the bus style select low, wr_strobe_n is a direction line (high reads, low writes) and rd_strobe_n is unused.
// - While sleep_request is high the device enters low-power mode at once, stops its oscillator and isolates host pins.
// - The device leaves low-power mode only when sleep_request is deasserted.
// - The falling edge of sleep_request resets every register to its default value.
// - The master reset is active high with bus style select high and active low with it low, and the host drives the matching polarity.
// - A low level on ring_detect_n means the modem sees a ringing signal.
// - A rising transition on ring_detect_n raises an interrupt while the modem-status interrupt is enabled.
// - Software reads the ring state in bit 6 of modem_ctrl_reg.
// - With the bus style select low, the interrupt pin is an active-low open-drain output needing a pull-up.
// - Host transfers use an 8-bit three-state data bus with bit 0 the least significant bit.
`ifndef HBC_MAP_SVH
`define HBC_MAP_SVH
`define HBC_DATA_W      8
`define HBC_ADDR_W      3
`define HBC_SYNC_W      18
// synchroniser vector layout
`define HBC_SY_STYLE    0
`define HBC_SY_RD_N     1
`define HBC_SY_WR_N     2
`define HBC_SY_CS_N     3
`define HBC_SY_SLEEP    4
`define HBC_SY_RING_N   5
`define HBC_SY_MRST     6
`define HBC_SY_DATA_LO  7
`define HBC_SY_DATA_HI  14
`define HBC_SY_ADDR_LO  15
`define HBC_SY_ADDR_HI  17
// idle pin levels loaded by the synchroniser in reset
`define HBC_SYNC_RST    18'h0002F
// register offsets on the host address lines
`define HBC_OFS_IER     3'h1
`define HBC_OFS_MCR     3'h4
// register fields and reset values
`define HBC_MCR_RST     8'h00
`define HBC_IER_RST     4'h0
`define HBC_MCR_IRQ_DRV 5
`define HBC_MCR_RING    6
`define HBC_IER_MSI     3
`define HBC_IER_W       4
`endif

// >>> hbc_pkg.sv
// types for the host bus control pins block
package hbc_pkg;
    typedef enum logic [2:0] {
        HBC_PWR_RUN   = 3'b001,
        HBC_PWR_SLEEP = 3'b010,
        HBC_PWR_WAKE  = 3'b100
    } hbc_pwr_e;
    typedef logic [7:0] hbc_byte_t;
endpackage : hbc_pkg

// >>> hbc_sync_if.sv
// carrier between the pin synchroniser and the control logic
`timescale 1ns/10ps
`include "hbc_map.svh"
interface hbc_sync_if;
    logic [`HBC_SYNC_W-1:0] raw;
    logic [`HBC_SYNC_W-1:0] synced;
    modport sync (input raw, output synced);
    modport user (output raw, input synced);
endinterface : hbc_sync_if

// >>> hbc_pin_sync.sv
// two-stage synchroniser for every host pin entering the core clock domain
`timescale 1ns/10ps
`include "hbc_map.svh"
module hbc_pin_sync
    import hbc_pkg::*;
(
    input  wire logic   core_clk_i,
    input  wire logic   sys_rst_i,
    hbc_sync_if.sync    pins
);
    logic [`HBC_SYNC_W-1:0] meta_r;
    logic [`HBC_SYNC_W-1:0] meta_nxt;
    logic [`HBC_SYNC_W-1:0] sync_r;
    logic [`HBC_SYNC_W-1:0] sync_nxt;

    always_comb begin
        meta_nxt = pins.raw;
        sync_nxt = meta_r;
        if (sys_rst_i) begin
            meta_nxt = `HBC_SYNC_RST;
            sync_nxt = `HBC_SYNC_RST;
        end
    end

    always_ff @(posedge core_clk_i) begin
        meta_r <= meta_nxt;
        sync_r <= sync_nxt;
    end

    assign pins.synced = sync_r;
endmodule : hbc_pin_sync

// >>> hbc_top.sv
// host bus control pins: bus style, strobes, reset polarity, sleep, ring and interrupt drive
`timescale 1ns/10ps
`include "hbc_map.svh"
module hbc_top
    import hbc_pkg::*;
(
    input  wire logic                   core_clk_i,
    input  wire logic                   sys_rst_i,
    input  wire logic                   bus_style_i,
    input  wire logic                   rd_strobe_n_i,
    input  wire logic                   wr_strobe_n_i,
    input  wire logic                   chip_sel_n_i,
    input  wire logic                   master_reset_i,
    input  wire logic                   sleep_request_i,
    input  wire logic                   ring_detect_n_i,
    input  wire logic [`HBC_ADDR_W-1:0] addr_i,
    input  wire logic [`HBC_DATA_W-1:0] data_i,
    output logic      [`HBC_DATA_W-1:0] data_o,
    output logic                        data_oe_o,
    output logic                        irq_o,
    output logic                        irq_oe_o,
    output logic                        sleep_mode_o,
    output logic                        osc_stop_o,
    output logic                        bus_isolate_o,
    output logic      [`HBC_DATA_W-1:0] modem_ctrl_o
);
    hbc_sync_if pin_bus ();

    assign pin_bus.raw = {addr_i, data_i, master_reset_i, ring_detect_n_i, sleep_request_i,
                          chip_sel_n_i, wr_strobe_n_i, rd_strobe_n_i, bus_style_i};

    hbc_pin_sync u_sync (
        .core_clk_i (core_clk_i),
        .sys_rst_i  (sys_rst_i),
        .pins       (pin_bus)
    );

    logic                   style_s;
    logic                   rd_n_s;
    logic                   wr_n_s;
    logic                   cs_n_s;
    logic                   sleep_s;
    logic                   ring_n_s;
    logic                   mrst_s;
    hbc_byte_t              wdata_s;
    logic [`HBC_ADDR_W-1:0] addr_s;

    assign style_s  = pin_bus.synced[`HBC_SY_STYLE];
    assign rd_n_s   = pin_bus.synced[`HBC_SY_RD_N];
    assign wr_n_s   = pin_bus.synced[`HBC_SY_WR_N];
    assign cs_n_s   = pin_bus.synced[`HBC_SY_CS_N];
    assign sleep_s  = pin_bus.synced[`HBC_SY_SLEEP];
    assign ring_n_s = pin_bus.synced[`HBC_SY_RING_N];
    assign mrst_s   = pin_bus.synced[`HBC_SY_MRST];
    assign wdata_s  = pin_bus.synced[`HBC_SY_DATA_HI:`HBC_SY_DATA_LO];
    assign addr_s   = pin_bus.synced[`HBC_SY_ADDR_HI:`HBC_SY_ADDR_LO];

    // read data for one offset; unmapped offsets read as zero
    function automatic hbc_byte_t read_mux(input logic [`HBC_ADDR_W-1:0] a,
                                           input hbc_byte_t modem_ctrl_reg,
                                           input logic [`HBC_IER_W-1:0] ier,
                                           input logic ring);
        hbc_byte_t d;
        d = '0;
        if (a == `HBC_OFS_MCR) begin
            d = modem_ctrl_reg;
            d[`HBC_MCR_RING] = ring;
        end else if (a == `HBC_OFS_IER) begin
            d[`HBC_IER_W-1:0] = ier;
        end
        return d;
    endfunction : read_mux

    // ---------------- power state ----------------
    hbc_pwr_e pwr_r;
    hbc_pwr_e pwr_nxt;

    always_comb begin
        pwr_nxt = pwr_r;
        case (pwr_r)
            HBC_PWR_RUN: begin
                if (sleep_s) pwr_nxt = HBC_PWR_SLEEP;
            end
            HBC_PWR_SLEEP: begin
                if (!sleep_s) pwr_nxt = HBC_PWR_WAKE;
            end
            HBC_PWR_WAKE: begin
                pwr_nxt = sleep_s ? HBC_PWR_SLEEP : HBC_PWR_RUN;
            end
            default: pwr_nxt = HBC_PWR_RUN;
        endcase
        if (sys_rst_i) pwr_nxt = HBC_PWR_RUN;
    end

    always_ff @(posedge core_clk_i) begin
        pwr_r <= pwr_nxt;
    end

    logic running;
    logic mrst_act;
    logic soft_rst;

    assign running  = (pwr_r == HBC_PWR_RUN);
    assign mrst_act = style_s ? mrst_s : !mrst_s;
    // the wake cycle doubles as the automatic reset after sleep
    assign soft_rst = mrst_act || (pwr_r == HBC_PWR_WAKE);

    // ---------------- strobe decode ----------------
    logic rd_act;
    logic wr_act;
    logic rd_act_r;
    logic wr_act_r;
    logic rd_start;
    logic wr_start;

    // in the second bus style the chip select times the access and wr_strobe_n gives direction
    always_comb begin
        if (style_s) begin
            rd_act = !rd_n_s;
            wr_act = !wr_n_s;
        end else begin
            rd_act = !cs_n_s && wr_n_s;
            wr_act = !cs_n_s && !wr_n_s;
        end
    end

    assign rd_start = rd_act && !rd_act_r && running && !soft_rst;
    assign wr_start = wr_act && !wr_act_r && running && !soft_rst;

    // ---------------- registers and ring event ----------------
    hbc_byte_t               mcr_r;
    hbc_byte_t               mcr_nxt;
    logic [`HBC_IER_W-1:0]   ier_r;
    logic [`HBC_IER_W-1:0]   ier_nxt;
    logic                    ring_n_prev_r;
    logic                    ring_delta_r;
    logic                    ring_delta_nxt;
    logic                    ring_rise;
    logic                    irq_pend;

    assign ring_rise = ring_n_s && !ring_n_prev_r;
    assign irq_pend  = ring_delta_r && ier_r[`HBC_IER_MSI];

    always_comb begin
        mcr_nxt        = mcr_r;
        ier_nxt        = ier_r;
        ring_delta_nxt = ring_delta_r;
        if (wr_start && addr_s == `HBC_OFS_MCR) begin
            mcr_nxt = wdata_s;
        end else if (wr_start && addr_s == `HBC_OFS_IER) begin
            ier_nxt = wdata_s[`HBC_IER_W-1:0];
        end
        // reading the modem control word acknowledges the ring event; a new edge wins
        if (rd_start && addr_s == `HBC_OFS_MCR) ring_delta_nxt = 1'b0;
        if (ring_rise && running) ring_delta_nxt = 1'b1;
        if (soft_rst || sys_rst_i) begin
            mcr_nxt        = `HBC_MCR_RST;
            ier_nxt        = `HBC_IER_RST;
            ring_delta_nxt = 1'b0;
        end
    end

    always_ff @(posedge core_clk_i) begin
        mcr_r         <= mcr_nxt;
        ier_r         <= ier_nxt;
        ring_delta_r  <= ring_delta_nxt;
        ring_n_prev_r <= sys_rst_i ? 1'b1 : ring_n_s;
        rd_act_r      <= sys_rst_i ? 1'b0 : rd_act;
        wr_act_r      <= sys_rst_i ? 1'b0 : wr_act;
    end

    // ---------------- output stage ----------------
    hbc_byte_t data_nxt;
    logic      data_oe_nxt;
    logic      irq_nxt;
    logic      irq_oe_nxt;

    always_comb begin
        data_nxt    = data_o;
        data_oe_nxt = rd_act && running && !soft_rst;
        if (rd_start) data_nxt = read_mux(addr_s, mcr_r, ier_r, !ring_n_s);
        if (style_s) begin
            if (mcr_r[`HBC_MCR_IRQ_DRV]) begin
                irq_nxt    = irq_pend;
                irq_oe_nxt = 1'b1;
            end else begin
                irq_nxt    = 1'b1;
                irq_oe_nxt = irq_pend;
            end
        end else begin
            irq_nxt    = 1'b0;
            irq_oe_nxt = irq_pend;
        end
        if (sys_rst_i) begin
            data_nxt    = '0;
            data_oe_nxt = 1'b0;
            irq_nxt     = 1'b0;
            irq_oe_nxt  = 1'b0;
        end
    end

    always_ff @(posedge core_clk_i) begin
        data_o        <= data_nxt;
        data_oe_o     <= data_oe_nxt;
        irq_o         <= irq_nxt;
        irq_oe_o      <= irq_oe_nxt;
        sleep_mode_o  <= !sys_rst_i && pwr_nxt == HBC_PWR_SLEEP;
        osc_stop_o    <= !sys_rst_i && pwr_nxt == HBC_PWR_SLEEP;
        bus_isolate_o <= !sys_rst_i && pwr_nxt == HBC_PWR_SLEEP;
        modem_ctrl_o  <= sys_rst_i ? `HBC_MCR_RST : mcr_nxt;
    end

    // ---------------- checks ----------------
    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (sys_rst_i);

    sequence s_sleeping;
        pwr_r == HBC_PWR_SLEEP;
    endsequence
    sequence s_wake_reset;
        pwr_r == HBC_PWR_WAKE ##1 (mcr_r == `HBC_MCR_RST && ier_r == `HBC_IER_RST);
    endsequence

    property p_irq_active;
        style_s && mcr_r[`HBC_MCR_IRQ_DRV] |=> irq_oe_o && irq_o == $past(irq_pend);
    endproperty
    a_irq_active: assert property (p_irq_active) else $error("irq not driven actively");

    property p_irq_open_src;
        style_s && !mcr_r[`HBC_MCR_IRQ_DRV] |=> irq_o && irq_oe_o == $past(irq_pend);
    endproperty
    a_irq_open_src: assert property (p_irq_open_src) else $error("irq not open-source");

    property p_irq_open_drain;
        !style_s |=> !irq_o && irq_oe_o == $past(irq_pend);
    endproperty
    a_irq_open_drain: assert property (p_irq_open_drain) else $error("irq not open-drain");

    property p_read_drive;
        style_s && !rd_n_s && running && !soft_rst |=> data_oe_o;
    endproperty
    a_read_drive: assert property (p_read_drive) else $error("read strobe not served");

    property p_rw_write;
        !style_s && !cs_n_s && !wr_n_s |=> !data_oe_o;
    endproperty
    a_rw_write: assert property (p_rw_write) else $error("bus driven during write");

    property p_sleep_enter;
        running && sleep_s |=> s_sleeping ##0 (sleep_mode_o && osc_stop_o && bus_isolate_o);
    endproperty
    a_sleep_enter: assert property (p_sleep_enter) else $error("sleep not entered");

    property p_wake;
        s_sleeping ##0 !sleep_s |=> s_wake_reset;
    endproperty
    a_wake: assert property (p_wake) else $error("no reset after sleep");

    property p_sleep_hold;
        s_sleeping ##0 !mrst_act |=> $stable(mcr_r) && $stable(ier_r) && !data_oe_o;
    endproperty
    a_sleep_hold: assert property (p_sleep_hold) else $error("access taken in sleep");

    property p_master_reset;
        mrst_act |=> mcr_r == `HBC_MCR_RST && !ring_delta_r;
    endproperty
    a_master_reset: assert property (p_master_reset) else $error("reset polarity wrong");

    property p_ring_event;
        ring_rise && running && !soft_rst && ier_r[`HBC_IER_MSI] |=> ##1 irq_oe_o || irq_o;
    endproperty
    a_ring_event: assert property (p_ring_event) else $error("ring edge lost");

    property p_ring_read;
        rd_start && addr_s == `HBC_OFS_MCR |=> data_o[`HBC_MCR_RING] == !$past(ring_n_s);
    endproperty
    a_ring_read: assert property (p_ring_read) else $error("ring bit wrong");
endmodule : hbc_top

// >>> hbc_host_model.sv
// host cpu model driving the strobe, address and data pins of the host port
`timescale 1ns/10ps
module hbc_host_model
    import hbc_pkg::*;
(
    input  wire logic       core_clk_i,
    input  wire logic       bus_style_i,
    input  wire logic       data_oe_i,
    input  wire hbc_byte_t  data_i,
    output logic            rd_strobe_n_o,
    output logic            wr_strobe_n_o,
    output logic            chip_sel_n_o,
    output logic [2:0]      addr_o,
    output hbc_byte_t       data_o
);
    initial begin
        rd_strobe_n_o = 1'b1;
        wr_strobe_n_o = 1'b1;
        chip_sel_n_o  = 1'b1;
        addr_o        = 3'h0;
        data_o        = 8'h00;
    end

    // one byte access; strobes held until the read answer, at most 8 clocks, or for 8 clocks on a write
    task automatic xfer(input logic wr, input logic [2:0] a, input hbc_byte_t d,
                        output hbc_byte_t q, output logic ok);
        int n;
        @(negedge core_clk_i);
        addr_o        = a;
        data_o        = d;
        wr_strobe_n_o = ~wr;
        rd_strobe_n_o = ~(bus_style_i & ~wr);
        chip_sel_n_o  = bus_style_i;
        ok = wr;
        q  = 8'h00;
        // device outputs are looked at on the falling edge, where they have settled
        for (n = 0; n < 8 && !(ok && !wr); n++) begin
            @(negedge core_clk_i);
            if (!wr && data_oe_i === 1'b1) begin
                ok = 1'b1;
                q  = data_i;
            end
        end
        rd_strobe_n_o = 1'b1;
        wr_strobe_n_o = 1'b1;
        chip_sel_n_o  = 1'b1;
        // a released bus must not keep showing the last byte
        data_o        = ~d;
        repeat (4) @(negedge core_clk_i);
    endtask : xfer
endmodule : hbc_host_model

// >>> host_bus_control_pins_tb.sv
// self-checking bench for the host bus control pins block
`timescale 1ns/10ps
module host_bus_control_pins_tb;
    import hbc_pkg::*;
    logic       core_clk = 1'b0;
    logic       sys_rst  = 1'b1;
    logic       style    = 1'b1;
    logic       mrst     = 1'b0;
    logic       sleep    = 1'b0;
    logic       ring_n   = 1'b0;
    logic       rd_n, wr_n, cs_n, oe, irq, irq_oe, slp, osc, iso;
    logic [2:0] addr;
    hbc_byte_t  hdata, ddata, modem_ctrl_reg, q;
    int         err_total  = 0;
    int         n_compared = 0;

    always #20 core_clk = ~core_clk;

    hbc_top uut (.core_clk_i(core_clk), .sys_rst_i(sys_rst), .bus_style_i(style),
        .rd_strobe_n_i(rd_n), .wr_strobe_n_i(wr_n), .chip_sel_n_i(cs_n),
        .master_reset_i(mrst), .sleep_request_i(sleep), .ring_detect_n_i(ring_n),
        .addr_i(addr), .data_i(hdata), .data_o(ddata), .data_oe_o(oe), .irq_o(irq),
        .irq_oe_o(irq_oe), .sleep_mode_o(slp), .osc_stop_o(osc),
        .bus_isolate_o(iso), .modem_ctrl_o(modem_ctrl_reg));

    hbc_host_model host (.core_clk_i(core_clk), .bus_style_i(style), .data_oe_i(oe),
        .data_i(ddata), .rd_strobe_n_o(rd_n), .wr_strobe_n_o(wr_n),
        .chip_sel_n_o(cs_n), .addr_o(addr), .data_o(hdata));

    task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
        n_compared++;
        if (g !== e) begin
            err_total++;
            $display("mismatch %s expected %h seen %h", nm, e, g);
        end
    endtask : chk

    task automatic wr(input logic [2:0] a, input hbc_byte_t d);
        logic ok;
        host.xfer(1'b1, a, d, q, ok);
    endtask : wr

    task automatic rd(input logic [2:0] a, input hbc_byte_t e, input string nm);
        logic ok;
        host.xfer(1'b0, a, 8'h00, q, ok);
        chk({nm, "_ack"}, 8'h01, {7'h00, ok});
        chk(nm, e, q);
    endtask : rd

    task automatic t_style1_rw;
        chk("mcr_rst", 8'h00, modem_ctrl_reg);
        wr(3'h4, 8'h25);
        chk("mcr_wr", 8'h25, modem_ctrl_reg);
        rd(3'h4, 8'h65, "mcr_rd");
        rd(3'h7, 8'h00, "unmapped_rd");
    endtask : t_style1_rw

    task automatic t_ring_irq;
        wr(3'h1, 8'h08);
        @(negedge core_clk);
        ring_n = 1'b1;
        repeat (5) @(negedge core_clk);
        chk("irq_drive", 8'h03, {6'h00, irq, irq_oe});
        wr(3'h4, 8'h05);
        chk("irq_open_src", 8'h03, {6'h00, irq, irq_oe});
        style = 1'b0;
        mrst  = 1'b1;
        repeat (4) @(negedge core_clk);
        chk("irq_open_drain", 8'h01, {6'h00, irq, irq_oe});
        rd(3'h4, 8'h05, "mcr_rd_style0");
        repeat (4) @(negedge core_clk);
        chk("irq_cleared", 8'h00, {7'h00, irq_oe});
        wr(3'h4, 8'h2A);
        chk("mcr_wr_style0", 8'h2A, modem_ctrl_reg);
    endtask : t_ring_irq

    task automatic t_mreset;
        mrst = 1'b0;
        repeat (4) @(negedge core_clk);
        mrst = 1'b1;
        repeat (4) @(negedge core_clk);
        chk("mrst_low", 8'h00, modem_ctrl_reg);
        style = 1'b1;
        mrst  = 1'b0;
        repeat (4) @(negedge core_clk);
        wr(3'h4, 8'h11);
        chk("mcr_pre_rst", 8'h11, modem_ctrl_reg);
        mrst = 1'b1;
        repeat (4) @(negedge core_clk);
        mrst = 1'b0;
        repeat (4) @(negedge core_clk);
        chk("mrst_high", 8'h00, modem_ctrl_reg);
    endtask : t_mreset

    task automatic t_sleep;
        logic ok_s;
        wr(3'h4, 8'h22);
        sleep = 1'b1;
        repeat (4) @(negedge core_clk);
        chk("sleep_pins", 8'h07, {5'h00, slp, osc, iso});
        wr(3'h4, 8'h33);
        chk("mcr_sleep_wr", 8'h22, modem_ctrl_reg);
        chk("sleep_oe", 8'h00, {7'h00, oe});
        host.xfer(1'b0, 3'h4, 8'h00, q, ok_s);
        chk("sleep_rd_ack", 8'h00, {7'h00, ok_s});
        repeat (10) @(negedge core_clk);
        chk("sleep_held", 8'h07, {5'h00, slp, osc, iso});
        sleep = 1'b0;
        repeat (5) @(negedge core_clk);
        chk("wake_pins", 8'h00, {5'h00, slp, osc, iso});
        chk("wake_mcr", 8'h00, modem_ctrl_reg);
        wr(3'h4, 8'h44);
        chk("mcr_after_wake", 8'h44, modem_ctrl_reg);
    endtask : t_sleep

    task automatic conclude;
        $display("compared %0d mismatches %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : conclude

    // the whole sequence needs well under 1000 clocks
    initial begin
        #(40 * 4000);
        err_total++;
        conclude();
    end

    initial begin
        repeat (5) @(negedge core_clk);
        sys_rst = 1'b0;
        repeat (3) @(negedge core_clk);
        t_style1_rw();
        t_ring_irq();
        t_mreset();
        t_sleep();
        conclude();
    end
endmodule : host_bus_control_pins_tb
